// File: inc/flash_pkg.sv
// constants, encodings and timing for the four-line program / erase sequencer
// assumes one 125 MHz core clock that oversamples the serial pins
//Function
//RL1: four-line program 32H runs only while four_line_enable is set
//RL2: program or erase acts only with write_enable_latch set beforehand
//RL3: host sends opcode, three address bytes, then data nibbles on four lines
//RL4: over 256 data bytes, only the last 256 of the page are kept
//RL5: under 256 bytes, unsent bytes of the page stay unchanged
//RL6: select must rise on a data byte boundary or the program is dropped
//RL7: valid program frame end starts a timed program cycle
//RL8: write_in_progress is 1 for the whole timed cycle, then 0
//RL9: write_enable_latch is cleared before each timed cycle ends
//RL10: program aimed at a protected page is not run
//RL11: sector erase 20H is opcode plus three address bytes on line 0
//RL12: erase ignores offset bits below the sector or block size
//RL13: host keeps select low from opcode through last address byte
//RL14: erase runs only if select rises right after the last address bit
//RL15: valid sector erase frame end starts a timed sector erase
//RL16: sector erase into a protected sector is rejected
//RL17: opcode 52H erases the whole addressed 32 KB block
//RL18: opcode D8H erases the whole addressed 64 KB block
//RL19: valid block erase frame end starts a timed block erase
//RL20: block erase into a protected block is not run
//RL21: data past the page end wraps to the page start
//RL22: erase writes all ones; program only clears bits
//RL23: while busy, program and erase frames are ignored
package flash_pkg;
   localparam logic [7:0] OP_SET_WRITE_LATCH = 8'h06;
   localparam logic [7:0] OP_QUAD_PROGRAM = 8'h32;
   localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
   localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
   localparam logic [7:0] OP_BLOCK64_ERASE = 8'hD8;
   localparam logic [4:0] OPC_LAST_BIT = 5'h07;
   localparam logic [4:0] ADDR_LAST_BIT = 5'h17;
   localparam int PAGE_BYTES = 256;
   localparam int PAGE_SHIFT = 8;
   localparam int SECTOR_SHIFT = 12;
   localparam int BLOCK32_SHIFT = 15;
   localparam int BLOCK64_SHIFT = 16;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam int DEFAULT_ADDR_W = 17;
   localparam int PROTECT_UNIT_SECTORS = 1;
   localparam logic [5:0] PIN_RESET = 6'h02;
   localparam int CLK_PERIOD_NS = 8;
   localparam int PROGRAM_CYCLE_TIME_US = 500;
   localparam int ERASE_CYCLE_TIME_US = 50000;
   localparam int PROGRAM_CYCLES = PROGRAM_CYCLE_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int ERASE_CYCLES = ERASE_CYCLE_TIME_US * 1000 / CLK_PERIOD_NS;
   typedef enum logic [2:0] {F_IDLE, F_OPC, F_ADDR, F_DATA, F_DONE, F_SKIP} frame_t;
   typedef enum logic [0:0] {EX_IDLE, EX_RUN} exec_t;
endpackage

// File: rtl/pin_sync.sv
// two-stage synchroniser for the serial pins
// assumes inputs are asynchronous to clk
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input wire logic clk, // core clock
   input wire logic rst, // synchronous reset
   input wire logic [WIDTH-1:0] async_in, // raw pin levels
   output logic [WIDTH-1:0] sync_out // levels after two flops
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   if (WIDTH < 1) begin : g_bad_width
      $error("pin_sync width must be at least one");
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_ff <= RST_VAL;
         sync_ff <= RST_VAL;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   assign sync_out = sync_ff;
endmodule

// File: rtl/serial_flash_program_erase.sv
// four-line page program and sector/block erase sequencer of a serial flash
// assumes mode-0 serial timing slow enough to oversample with clk
module serial_flash_program_erase import flash_pkg::*; #(
   parameter int ADDR_W = DEFAULT_ADDR_W,
   parameter int PROG_CYCLES = PROGRAM_CYCLES,
   parameter int ERASE_CYCLES_P = ERASE_CYCLES
) (
   input wire logic clk, // core clock
   input wire logic rst, // synchronous reset
   input wire logic sclk, // serial clock pin
   input wire logic cs_n, // chip select pin
   input wire logic data_line_0, // serial data line 0
   input wire logic data_line_1, // serial data line 1
   input wire logic data_line_2, // serial data line 2
   input wire logic data_line_3, // serial data line 3
   input wire logic four_line_enable, // status quad-enable bit
   input wire logic protect_bit_0, // block protect bit 0
   input wire logic protect_bit_1, // block protect bit 1
   input wire logic protect_bit_2, // block protect bit 2
   input wire logic protect_bit_3, // block protect bit 3
   input wire logic protect_bit_4, // block protect bit 4
   input wire logic [ADDR_W-1:0] mem_rd_addr, // array read address
   output logic [7:0] mem_rd_data, // array read data
   output logic write_enable_latch, // write enable latch status
   output logic write_in_progress // busy status
);
   localparam int NSECT_W = ADDR_W - SECTOR_SHIFT;

   if (ADDR_W < BLOCK64_SHIFT || ADDR_W > 24
       || PROG_CYCLES < 1 || ERASE_CYCLES_P < 1) begin : g_bad_param
      $error("unsupported array size or cycle count");
   end

   logic [5:0] pins_s;
   logic sclk_s;
   logic cs_n_s;
   logic [3:0] dl_s;
   logic sclk_d_ff;
   logic cs_d_ff;
   logic sclk_rise;
   logic cs_rise;
   logic bit_edge;

   pin_sync #(.WIDTH(6), .RST_VAL(PIN_RESET)) u_pin_sync (
      .clk(clk),
      .rst(rst),
      .async_in({data_line_3, data_line_2, data_line_1, data_line_0, cs_n, sclk}),
      .sync_out(pins_s)
   );

   assign {dl_s, cs_n_s, sclk_s} = pins_s;

   always_ff @(posedge clk) begin
      if (rst) begin
         sclk_d_ff <= 1'b0;
         cs_d_ff <= 1'b1;
      end else begin
         sclk_d_ff <= sclk_s;
         cs_d_ff <= cs_n_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d_ff;
   assign cs_rise = cs_n_s & ~cs_d_ff;
   assign bit_edge = sclk_rise & ~cs_n_s;

   // frame decoding
   frame_t state_ff;
   logic [4:0] cnt_ff;
   logic [23:0] shift_ff;
   logic [7:0] opc_ff;
   logic [23:0] addr_ff;
   logic nib_ff;
   logic [3:0] hi_ff;
   logic [7:0] col_ff;
   logic any_ff;
   logic wip_ff;
   logic wel_ff;
   logic [7:0] nxt_opc;
   logic [23:0] nxt_addr;
   logic opc_done;
   logic addr_done;
   logic byte_stb;
   logic is_erase_op;

   assign nxt_opc = {shift_ff[6:0], dl_s[0]};
   assign nxt_addr = {shift_ff[22:0], dl_s[0]};
   assign opc_done = bit_edge && state_ff == F_OPC && cnt_ff == OPC_LAST_BIT;
   assign addr_done = bit_edge && state_ff == F_ADDR && cnt_ff == ADDR_LAST_BIT;
   assign byte_stb = bit_edge && state_ff == F_DATA && nib_ff;
   assign is_erase_op = opc_ff == OP_SECTOR_ERASE || opc_ff == OP_BLOCK32_ERASE
                        || opc_ff == OP_BLOCK64_ERASE;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= F_IDLE;
         cnt_ff <= '0;
         shift_ff <= '0;
         opc_ff <= '0;
         addr_ff <= '0;
      end else if (cs_n_s) begin
         state_ff <= F_IDLE; // RL13
      end else if (state_ff == F_IDLE) begin
         state_ff <= F_OPC;
         cnt_ff <= '0;
      end else if (bit_edge) begin
         shift_ff <= nxt_addr; // RL11
         cnt_ff <= cnt_ff + 5'h01;
         case (state_ff)
            F_OPC: begin
               if (cnt_ff == OPC_LAST_BIT) begin
                  opc_ff <= nxt_opc;
                  cnt_ff <= '0;
                  // busy device drops new frames at the opcode
                  if (wip_ff) begin
                     state_ff <= F_SKIP; // RL23
                  end else if (nxt_opc == OP_QUAD_PROGRAM) begin
                     state_ff <= four_line_enable ? F_ADDR : F_SKIP; // RL1
                  end else if (nxt_opc == OP_SECTOR_ERASE || nxt_opc == OP_BLOCK32_ERASE
                               || nxt_opc == OP_BLOCK64_ERASE) begin
                     state_ff <= F_ADDR;
                  end else if (nxt_opc == OP_SET_WRITE_LATCH) begin
                     state_ff <= F_DONE;
                  end else begin
                     state_ff <= F_SKIP;
                  end
               end
            end
            F_ADDR: begin
               if (cnt_ff == ADDR_LAST_BIT) begin
                  addr_ff <= nxt_addr;
                  state_ff <= (opc_ff == OP_QUAD_PROGRAM) ? F_DATA : F_DONE;
               end
            end
            F_DONE: state_ff <= F_SKIP; // RL14
            default: state_ff <= state_ff;
         endcase
      end
   end

   // data nibbles, high nibble first, on all four lines
   always_ff @(posedge clk) begin
      if (rst) begin
         nib_ff <= 1'b0;
         hi_ff <= '0;
         col_ff <= '0;
         any_ff <= 1'b0;
      end else if (addr_done) begin
         nib_ff <= 1'b0;
         any_ff <= 1'b0;
         col_ff <= nxt_addr[7:0];
      end else if (bit_edge && state_ff == F_DATA) begin
         nib_ff <= ~nib_ff; // RL3
         hi_ff <= dl_s;
         if (nib_ff) begin
            col_ff <= col_ff + 8'h01; // RL21
            any_ff <= 1'b1;
         end
      end
   end

   // page buffer; a later byte to the same column replaces the earlier one
   logic [7:0] page_mem [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] valid_ff;

   always_ff @(posedge clk) begin
      if (byte_stb) begin
         page_mem[col_ff] <= {hi_ff, dl_s}; // RL4
      end
   end

   always_ff @(posedge clk) begin
      if (rst || addr_done) begin
         valid_ff <= '0;
      end else if (byte_stb) begin
         valid_ff[col_ff] <= 1'b1; // RL5
      end
   end

   // region size and protection check
   logic [ADDR_W-1:0] reg_mask;
   logic [ADDR_W-1:0] top_addr;
   logic [NSECT_W-1:0] from_top;
   logic [4:0] prot_val;
   logic prot_hit;
   int region_shift;

   always_comb begin
      case (opc_ff)
         OP_SECTOR_ERASE: region_shift = SECTOR_SHIFT;
         OP_BLOCK32_ERASE: region_shift = BLOCK32_SHIFT; // RL17
         OP_BLOCK64_ERASE: region_shift = BLOCK64_SHIFT; // RL18
         default: region_shift = PAGE_SHIFT;
      endcase
   end

   assign reg_mask = ADDR_W'((32'd1 << region_shift) - 32'd1);
   // protection grows down from the top of the array
   assign top_addr = addr_ff[ADDR_W-1:0] | reg_mask;
   assign from_top = ~top_addr[ADDR_W-1:SECTOR_SHIFT];
   assign prot_val = {protect_bit_4, protect_bit_3, protect_bit_2, protect_bit_1, protect_bit_0};
   assign prot_hit = 32'(from_top) < 32'(prot_val) * 32'(PROTECT_UNIT_SECTORS);

   // start decision at the rising edge of select
   logic go_latch;
   logic erase_frame;
   logic go_prog;
   logic go_erase;

   assign go_latch = cs_rise && state_ff == F_DONE && opc_ff == OP_SET_WRITE_LATCH;
   assign erase_frame = cs_rise && state_ff == F_DONE && is_erase_op; // RL14
   assign go_prog = cs_rise && state_ff == F_DATA && any_ff && !nib_ff // RL6
                    && wel_ff && !wip_ff && !prot_hit; // RL2 RL10
   assign go_erase = erase_frame && wel_ff && !wip_ff && !prot_hit; // RL2 RL16 RL20

   always_ff @(posedge clk) begin
      if (rst) begin
         wel_ff <= 1'b0;
      end else if (go_prog || go_erase) begin
         wel_ff <= 1'b0; // RL9
      end else if (go_latch) begin
         wel_ff <= 1'b1;
      end
   end

   // self-timed cycle: array walk and timer run together
   exec_t ex_ff;
   logic ex_erase_ff;
   logic walking_ff;
   logic [ADDR_W-1:0] base_ff;
   logic [ADDR_W-1:0] wlen_ff;
   logic [ADDR_W-1:0] walk_ff;
   logic [31:0] timer_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         ex_ff <= EX_IDLE;
         wip_ff <= 1'b0;
         ex_erase_ff <= 1'b0;
         walking_ff <= 1'b0;
         base_ff <= '0;
         wlen_ff <= '0;
         walk_ff <= '0;
         timer_ff <= '0;
      end else begin
         case (ex_ff)
            EX_IDLE: begin
               if (go_prog || go_erase) begin
                  ex_ff <= EX_RUN;
                  wip_ff <= 1'b1; // RL7 RL15 RL19
                  ex_erase_ff <= go_erase;
                  walking_ff <= 1'b1;
                  base_ff <= addr_ff[ADDR_W-1:0] & ~reg_mask; // RL12
                  wlen_ff <= reg_mask;
                  walk_ff <= '0;
                  timer_ff <= go_prog ? 32'(PROG_CYCLES - 1) : 32'(ERASE_CYCLES_P - 1);
               end
            end
            EX_RUN: begin
               if (walking_ff) begin
                  walk_ff <= walk_ff + ADDR_W'(1);
                  walking_ff <= walk_ff != wlen_ff;
               end
               if (timer_ff != 32'h0) begin
                  timer_ff <= timer_ff - 32'h1;
               end else if (!walking_ff) begin
                  ex_ff <= EX_IDLE;
                  wip_ff <= 1'b0; // RL8
               end
            end
            default: ex_ff <= EX_IDLE;
         endcase
      end
   end

   // storage array; contents are undefined until first erased
   logic [7:0] mem [2**ADDR_W];
   logic [ADDR_W-1:0] wr_addr;
   logic [7:0] rd_ff;

   assign wr_addr = base_ff | walk_ff;

   always_ff @(posedge clk) begin
      if (ex_ff == EX_RUN && walking_ff) begin
         if (ex_erase_ff) begin
            mem[wr_addr] <= ERASED_BYTE; // RL22
         end else if (valid_ff[walk_ff[7:0]]) begin
            mem[wr_addr] <= mem[wr_addr] & page_mem[walk_ff[7:0]]; // RL22
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_ff <= '0;
      end else begin
         rd_ff <= mem[mem_rd_addr];
      end
   end

   assign mem_rd_data = rd_ff;
   assign write_enable_latch = wel_ff;
   assign write_in_progress = wip_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence start_s;
      go_prog || go_erase;
   endsequence

   sequence no_start_s;
      ##1 !$rose(wip_ff);
   endsequence

   prog_start_a: assert property (go_prog |=> wip_ff && ex_ff == EX_RUN) // RL7
      else $error("program frame did not start a cycle");
   erase_start_a: assert property ( // RL15 RL19
      erase_frame && wel_ff && !wip_ff && !prot_hit |=> wip_ff && ex_erase_ff)
      else $error("erase frame did not start a cycle");
   busy_hold_a: assert property (start_s |=> wip_ff [*8]) // RL8
      else $error("busy dropped early");
   latch_clear_a: assert property (start_s |=> !wel_ff ##1 !wel_ff) // RL9
      else $error("write latch not cleared at cycle start");
   latch_need_a: assert property (start_s |-> wel_ff) // RL2
      else $error("cycle started with latch clear");
   protect_gate_a: assert property (start_s |-> !prot_hit) // RL10 RL16 RL20
      else $error("protected region was modified");
   busy_ignore_a: assert property (cs_rise && wip_ff |-> no_start_s) // RL23
      else $error("frame accepted while busy");
   // a latch command framed while busy must not take effect either
   latch_busy_a: assert property (wip_ff |=> !$rose(wel_ff)) // RL23
      else $error("write latch set while busy");
   quad_gate_a: assert property ( // RL1
      opc_done && nxt_opc == OP_QUAD_PROGRAM && !four_line_enable |=> state_ff == F_SKIP)
      else $error("four-line program accepted without enable");
   byte_edge_a: assert property (cs_rise && state_ff == F_DATA && nib_ff |-> no_start_s) // RL6
      else $error("program ran after partial byte");
   erase_edge_a: assert property ( // RL14
      cs_rise && is_erase_op && state_ff inside {F_ADDR, F_SKIP} |-> no_start_s)
      else $error("erase ran with wrong frame length");
   col_wrap_a: assert property (byte_stb |=> col_ff == 8'($past(col_ff) + 8'h01)) // RL21
      else $error("page column did not advance");
endmodule

// File: test/flash_host_model.sv
// host controller model: drives select, serial clock and the four data lines
// assumes mode-0 framing; the serial clock stays low between frames
module flash_host_model (
   output logic sclk, // serial clock, 125 ns period inside frames
   output logic cs_n, // chip select
   output logic [3:0] dl // data lines, bit 3 is line 3
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] dbuf [0:299];
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      dl = 4'hA;
   end
   task automatic tick(input logic [3:0] v);
      dl = v;
      #62.5 sclk = 1'b1;
      #62.5 sclk = 1'b0;
   endtask
   // nab counts address bits; 23 or 25 breaks the frame on purpose
   task automatic send(input logic [7:0] op, input logic [23:0] a, input int nab,
                       input int nnib);
      logic b;
      #3 cs_n = 1'b0;
      #62.5;
      for (int i = 0; i < 8 + nab; i++) begin
         b = (i < 8) ? op[7 - i] : ((i < 32) ? a[31 - i] : 1'b1);
         // unused lines carry the inverse so nothing rides on stale levels
         tick({{3{~b}}, b});
      end
      for (int i = 0; i < nnib; i++) begin
         tick(i[0] ? dbuf[i / 2][3:0] : dbuf[i / 2][7:4]);
      end
      #62.5 cs_n = 1'b1;
      dl = ~dl;
      #1000;
   endtask
endmodule

// File: test/testbench.sv
// self-checking bench for the four-line program and erase sequencer
// assumes the host model owns the pins and the array read port is free for checks
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import flash_pkg::*;
   localparam int AW = 16;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic sclk;
   logic cs_n;
   logic [3:0] dl;
   logic quad_en = 1'b0;
   logic [4:0] prot = 5'h00;
   logic [AW-1:0] rd_addr = '0;
   logic [7:0] rd_data;
   logic latch;
   logic busy;
   logic probe = 1'b0;
   logic probe_d = 1'b0;
   logic [8:0] exp_q [$];
   logic [8:0] e;
   logic [7:0] got;
   logic [7:0] old;
   logic [7:0] pg [0:255];
   int ra;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;

   flash_host_model u_host (.sclk(sclk), .cs_n(cs_n), .dl(dl));
   serial_flash_program_erase #(.ADDR_W(AW), .PROG_CYCLES(300), .ERASE_CYCLES_P(300)) u_dut (
      .clk(clk), .rst(rst), .sclk(sclk), .cs_n(cs_n),
      .data_line_0(dl[0]), .data_line_1(dl[1]), .data_line_2(dl[2]), .data_line_3(dl[3]),
      .four_line_enable(quad_en), .protect_bit_0(prot[0]), .protect_bit_1(prot[1]),
      .protect_bit_2(prot[2]), .protect_bit_3(prot[3]), .protect_bit_4(prot[4]),
      .mem_rd_addr(rd_addr), .mem_rd_data(rd_data),
      .write_enable_latch(latch), .write_in_progress(busy));

   always #4 clk = ~clk;
   always @(posedge clk) probe_d <= probe;

   task automatic complete_run();
      if (n_fail == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         n_fail = n_fail + 1;
         complete_run();
      end
   end

   // results land one clock after the probe; compare on the falling edge
   always @(negedge clk) begin
      if (probe_d) begin
         e = exp_q.pop_front();
         got = e[8] ? {6'h00, latch, busy} : rd_data;
         checked = checked + 1;
         if (got !== e[7:0]) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, e[7:0]);
         end
      end
   end

   // st=1: status {latch, busy}; st=0: array byte at a
   task automatic look(input logic st, input logic [AW-1:0] a, input logic [7:0] v);
      @(posedge clk);
      rd_addr <= a;
      probe <= 1'b1;
      exp_q.push_back({st, v});
      @(posedge clk);
      probe <= 1'b0;
   endtask

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 40000) begin
         @(posedge clk);
         n++;
      end
      repeat (4) @(posedge clk);
   endtask

   task automatic set_write_latch_cmd();
      u_host.send(OP_SET_WRITE_LATCH, 24'h000000, 0, 0);
   endtask

   task automatic fill(input int n);
      for (int i = 0; i < n; i++) u_host.dbuf[i] = 8'($urandom);
   endtask

   // page was erased, so programmed bytes read back as sent
   task automatic check_page(input logic [AW-1:0] base, input logic [7:0] col, input int n);
      for (int i = 0; i < 256; i++) pg[i] = ERASED_BYTE;
      for (int i = 0; i < n; i++) pg[8'(col + i)] = u_host.dbuf[i];
      for (int i = 0; i < 256; i++) look(1'b0, base | AW'(i), pg[i]);
   endtask

   initial begin
      void'($urandom(32'h1214));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      look(1'b1, 16'h0000, 8'h00);
      set_write_latch_cmd();
      look(1'b1, 16'h0000, 8'h02);
      prot <= 5'h01;
      u_host.send(OP_BLOCK64_ERASE, 24'h001234, 24, 0);
      look(1'b1, 16'h0000, 8'h02);
      ra = $urandom % 32768;
      u_host.send(OP_BLOCK32_ERASE, 24'(ra), 24, 0);
      look(1'b1, 16'h0000, 8'h01);
      wait_idle();
      look(1'b1, 16'h0000, 8'h00);
      look(1'b0, 16'h0000, ERASED_BYTE);
      look(1'b0, 16'h7FFF, ERASED_BYTE);
      set_write_latch_cmd();
      u_host.send(OP_SECTOR_ERASE, 24'h000100, 25, 0);
      look(1'b1, 16'h0000, 8'h02);
      u_host.send(OP_SECTOR_ERASE, 24'h000100, 23, 0);
      look(1'b1, 16'h0000, 8'h02);
      u_host.send(OP_SECTOR_ERASE, 24'h00F010, 24, 0);
      look(1'b1, 16'h0000, 8'h02);
      fill(4);
      u_host.send(OP_QUAD_PROGRAM, 24'h000010, 24, 8);
      look(1'b1, 16'h0000, 8'h02);
      quad_en <= 1'b1;
      u_host.send(OP_QUAD_PROGRAM, 24'h00FF00, 24, 8);
      look(1'b1, 16'h0000, 8'h02);
      u_host.send(OP_QUAD_PROGRAM, 24'h000010, 24, 7);
      look(1'b1, 16'h0000, 8'h02);
      fill(20);
      u_host.send(OP_QUAD_PROGRAM, 24'h0000F0, 24, 40);
      look(1'b1, 16'h0000, 8'h01);
      set_write_latch_cmd();
      wait_idle();
      look(1'b1, 16'h0000, 8'h00);
      u_host.send(OP_QUAD_PROGRAM, 24'h000010, 24, 8);
      look(1'b1, 16'h0000, 8'h00);
      check_page(16'h0000, 8'hF0, 20);
      set_write_latch_cmd();
      fill(258);
      u_host.send(OP_QUAD_PROGRAM, 24'h000100, 24, 516);
      wait_idle();
      check_page(16'h0100, 8'h00, 258);
      old = u_host.dbuf[256];
      fill(1);
      set_write_latch_cmd();
      u_host.send(OP_QUAD_PROGRAM, 24'h000100, 24, 2);
      wait_idle();
      look(1'b0, 16'h0100, old & u_host.dbuf[0]);
      set_write_latch_cmd();
      u_host.send(OP_SECTOR_ERASE, 24'h0001A5, 24, 0);
      look(1'b1, 16'h0000, 8'h01);
      wait_idle();
      check_page(16'h0000, 8'h00, 0);
      check_page(16'h0100, 8'h00, 0);
      repeat (2) @(posedge clk);
      complete_run();
   end
endmodule
